// ### design/ucode_pkg.sv
package ucode_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W    = 16;  // Datapath word
    localparam int CSA_W     = 9;   // Control store address
    localparam int SHCNT_W   = 8;   // Shift counter
    localparam int KEY_W     = 4;   // Key registers
    localparam int NUM_GPR   = 16;  // General registers

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    localparam logic [7:0]  SHCNT_RESET = 8'h00;
    localparam logic [3:0]  KEY_RESET   = 4'h0;
    localparam logic [8:0]  CSA_RESET   = 9'h000;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [2:0] DEST_PC    = 3'h1;  // Program counter
    localparam logic [2:0] DEST_SHCNT = 3'h2;  // Shift counter
    localparam logic [2:0] DEST_KEY   = 3'h6;  // Processor key
    localparam logic [1:0] FILL_OWN   = 2'h0;  // Circular
    localparam logic [1:0] FILL_GPR   = 2'h1;  // Double length
    localparam logic [1:0] FILL_ALT   = 2'h2;  // Inverted ALU bit / keep sign
    localparam logic [1:0] FILL_LAST  = 2'h3;  // Zero / shift flag
    localparam logic [3:0] OP_MIR_LD  = 4'h4;  // Input reg + buffer

    // ------------------------------------------------------------
    // Microinstruction fields used by this block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] a_register_select;
        logic [1:0] b_bus_source_select;
        logic       gpr_store_flag;
        logic [2:0] special_dest_select;
        logic [1:0] memory_cycle_code;
        logic [3:0] memory_op_code;
        logic       opreg_shift_on;
        logic       shift_direction;
        logic [1:0] fill_bit_select;
        logic       gpr_shift_flag_sample;
        logic [3:0] ir_field_picker;
        logic [3:0] low_address_or_mask;
        logic       bit4_mask;
        logic [3:0] low_address_bits;
        logic [4:0] high_address_bits;
        logic [1:0] extract_control;
        logic [1:0] test_mode_select;
        logic [3:0] condition_select;
        logic       shcnt_inc;
        logic       pc_inc;
    } micro_type;

    // Memory side transfer strobes
    typedef struct packed {
        logic        data_load;
        logic        addr_load;
        logic        mir_load;
        logic        ior_load;
        logic [15:0] word;
        logic [3:0]  key;
    } mem_xfer_type;

endpackage : ucode_pkg

// ### design/microcode_datapath_sequencer.sv
//
// Behaviour
// [RL1] ALU result writes selected general register
// [RL2] Special destination code loads PC/opreg/counter/key
// [RL3] General and special register load together
// [RL4] Memory data/address loads need started cycle
// [RL5] Code 00/0100 loads input reg, buffer
// [RL6] Code 00/111X hands result to I/O
// [RL7] Eight-bit shift counter increments independently
// [RL8] Counter overflow test true at all ones
// [RL9] Counter test sees pre-increment value
// [RL10] Incremented PC used as memory address
// [RL11] Microcode avoids PC increment with ALU use
// [RL12] Processor key accompanies processor memory operations
// [RL13] I/O key accompanies I/O memory operations
// [RL14] Operand register shifts only when enabled
// [RL15] Left shift fill chosen by fill code
// [RL16] Right shift fill chosen by fill code
// [RL17] Operand shift alongside shifted register input
// [RL18] Normal next address from low, high fields
// [RL19] OR-in mask into address bits 1-4
// [RL20] OR-in suppressed on extract, interrupt, I/O, page
// [RL21] Shift flag samples selected register bit 15
// [RL22] No register write with literal or mask
// [RL23] Nine-bit address registered each cycle
// [RL24] All state updates on one clock edge
`timescale 1ns/1ns
module microcode_datapath_sequencer
    import ucode_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Current microinstruction and ALU
    input  wire ucode_pkg::micro_type    micro,
    input  wire logic [15:0]             alu_result,
    input  wire logic                    interrupts_allowed,
    // Memory and I/O control
    input  wire logic                    mem_cycle_started,
    input  wire logic                    io_mem_active,
    input  wire logic                    io_key_load,
    input  wire logic [3:0]              io_key_in,
    // Register state seen by the datapath
    output logic [15:0]                  a_reg_word,
    output logic [15:0]                  gpr0_word,
    output logic [15:0]                  program_counter,
    output logic [15:0]                  operand_reg,
    output logic [7:0]                   shift_counter,
    output logic                         shift_counter_ovf,
    output logic                         shift_out_flag,
    // Memory side
    output logic [15:0]                  mem_address,
    output ucode_pkg::mem_xfer_type      mem_xfer,
    // Sequencer
    output logic [8:0]                   control_store_addr
);
    import ucode_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] gpr [NUM_GPR];  // General register file
    logic [3:0]  proc_key;       // Processor key
    logic [3:0]  io_key;         // I/O key

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic no_literal  = ~micro.b_bus_source_select[1];
    wire logic cycle_req   = micro.memory_cycle_code != 2'h0;
    wire logic cyc_none    = ~cycle_req;
    wire logic io_request  = cyc_none
                           & (micro.memory_op_code[3:1] == 3'h7);
    wire logic page_jump   = (micro.test_mode_select == 2'h0)
                           & (micro.memory_cycle_code == 2'h2)
                           & micro.condition_select[2];
    wire logic extracting  = (micro.extract_control == 2'h1)
                           | (micro.extract_control == 2'h2);
    // [RL1] Gated register write
    // [RL22] Literal blocks write
    wire logic gpr_we      = micro.gpr_store_flag & no_literal;
    wire logic [15:0] a_word = gpr[micro.a_register_select];
    // [RL2] Special destination decode
    // [RL3] Independent of register write
    wire logic pc_ld    = micro.special_dest_select == DEST_PC;
    wire logic sc_ld    = micro.special_dest_select == DEST_SHCNT;
    wire logic key_ld   = micro.special_dest_select == DEST_KEY;
    wire logic opr_ld   = micro.special_dest_select[1:0] == 2'h3;
    // [RL4] Indirect memory transfers
    wire logic data_go  = cycle_req & micro.memory_op_code[1]
                        & mem_cycle_started;
    wire logic addr_go  = cycle_req & (micro.memory_op_code[3:2] == 2'h1)
                        & mem_cycle_started;
    // [RL5] Input register and buffer load
    wire logic mir_go   = cyc_none & (micro.memory_op_code == OP_MIR_LD);

    // [RL10] Incremented PC feeds address
    wire logic [15:0] pc_plus = program_counter + 16'h0001;
    wire logic [15:0] pc_next_addr =
        micro.pc_inc ? pc_plus : program_counter;

    // ------------------------------------------------------------
    // Operand register shift
    // ------------------------------------------------------------
    // [RL14] Shift enable
    // [RL17] Shift is independent of A-input use
    wire logic opr_shift = no_literal & micro.opreg_shift_on;
    logic left_fill;   // New bit 0
    logic right_fill;  // New bit 15

    // [RL15] Left fill select
    always_comb begin
        case (micro.fill_bit_select)
            FILL_OWN: left_fill = operand_reg[15];
            FILL_GPR: left_fill = a_word[15];
            FILL_ALT: left_fill = ~alu_result[15];
            default:  left_fill = 1'b0;
        endcase
    end

    // [RL16] Right fill select
    always_comb begin
        case (micro.fill_bit_select)
            FILL_OWN: right_fill = operand_reg[0];
            FILL_GPR: right_fill = a_word[0];
            FILL_ALT: right_fill = operand_reg[15];
            default:  right_fill = shift_out_flag;
        endcase
    end

    // Load wins over shift when both are coded
    wire logic [15:0] next_operand =
        opr_ld ? alu_result :
        !opr_shift ? operand_reg :
        micro.shift_direction ? {right_fill, operand_reg[15:1]}
                              : {operand_reg[14:0], left_fill};

    // [RL7] Counter increment path
    wire logic [7:0] next_shift_counter =
        sc_ld ? alu_result[7:0] :
        micro.shcnt_inc ? shift_counter + 8'h01 : shift_counter;

    // ------------------------------------------------------------
    // Next address
    // ------------------------------------------------------------
    // [RL20] OR-in suppression
    wire logic or_in_ok = ~extracting & ~interrupts_allowed
                        & ~io_request & ~page_jump;
    // [RL18] Normal address fields
    // [RL19] OR-in into bits 1-4
    wire logic [8:0] next_csa =
        {micro.high_address_bits, micro.low_address_bits}
        | (or_in_ok ? {4'h0, micro.low_address_or_mask, 1'b0} : 9'h000);

    // ------------------------------------------------------------
    // General registers
    // ------------------------------------------------------------
    // [RL24] Same edge as all other state
    always_ff @(posedge clk) begin
        if (gpr_we) begin
            gpr[micro.a_register_select] <= alu_result;
        end
    end

    // ------------------------------------------------------------
    // Special registers and flags
    // ------------------------------------------------------------
    // [RL24] One clock edge per microinstruction
    always_ff @(posedge clk) begin
        if (reset) begin
            program_counter <= DATA_RESET;
            operand_reg     <= DATA_RESET;
            shift_counter   <= SHCNT_RESET;
            proc_key        <= KEY_RESET;
            io_key          <= KEY_RESET;
            shift_out_flag  <= 1'b0;
        end else begin
            program_counter <= pc_ld ? alu_result : pc_next_addr;
            operand_reg     <= next_operand;
            shift_counter   <= next_shift_counter;
            proc_key        <= key_ld ? alu_result[3:0] : proc_key;
            io_key          <= io_key_load ? io_key_in : io_key;
            // [RL21] Shift flag sample
            if (no_literal && micro.gpr_shift_flag_sample) begin
                shift_out_flag <= a_word[15];
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            control_store_addr <= CSA_RESET;
            mem_address        <= DATA_RESET;
            mem_xfer           <= '0;
            a_reg_word         <= DATA_RESET;
            gpr0_word          <= DATA_RESET;
            shift_counter_ovf  <= 1'b0;
        end else begin
            // [RL23] Registered next address
            control_store_addr <= next_csa;
            // [RL10] Memory address from PC, ALU when loaded
            mem_address <= addr_go ? alu_result : pc_next_addr;
            mem_xfer.data_load <= data_go;
            mem_xfer.addr_load <= addr_go;
            mem_xfer.mir_load  <= mir_go;
            // [RL6] I/O control takes the word
            mem_xfer.ior_load  <= io_request;
            mem_xfer.word      <= alu_result;
            // [RL12] Processor key
            // [RL13] I/O key when I/O owns memory
            mem_xfer.key <= io_mem_active ? io_key : proc_key;
            a_reg_word   <= gpr_we ? alu_result : a_word;
            gpr0_word    <= (gpr_we && micro.a_register_select == 4'h0)
                          ? alu_result : gpr[0];
            // [RL8] All ones test
            // [RL9] Value before increment is what is tested
            shift_counter_ovf <= &next_shift_counter;
        end
    end

endmodule : microcode_datapath_sequencer

// ### sim/mem_io_model.sv
`timescale 1ns/1ns
module mem_io_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Answers from memory and I/O control
    output logic            mem_cycle_started,
    output logic            io_mem_active,
    output logic            io_key_load,
    output logic [3:0]      io_key_in
);
    logic [7:0] r = 8'h0C;  // Own pattern source

    initial begin
        mem_cycle_started = 1'b0;
        io_mem_active = 1'b0;
        io_key_load = 1'b0;
        io_key_in = 4'h0;
    end

    // Grants come at once or after a stall, so cycles can fail to start
    always @(negedge clk) begin
        r <= {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
        mem_cycle_started <= !reset && (r[0] | r[1]);
        io_mem_active <= r[2] & r[5];
        io_key_load <= r[3] & r[6];
        io_key_in <= r[7:4];
    end
endmodule : mem_io_model

// ### sim/mds_asserts.sv
`timescale 1ns/1ns
module mds_asserts
    import ucode_pkg::*;
(
    // Clock, reset and inputs
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire ucode_pkg::micro_type     micro,
    input  wire logic [15:0]              alu_result,
    input  wire logic                     mem_cycle_started,
    // Registered outputs
    input  wire logic [15:0]              gpr0_word,
    input  wire logic [15:0]              program_counter,
    input  wire logic [15:0]              operand_reg,
    input  wire logic [7:0]               shift_counter,
    input  wire logic                     shift_counter_ovf,
    input  wire ucode_pkg::mem_xfer_type  mem_xfer,
    input  wire logic [8:0]               control_store_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Literal or mask blocks writes; extraction blocks the OR-in
    wire logic lit  = micro.b_bus_source_select[1];
    wire logic norm = micro.extract_control == 2'h1 && !micro.bit4_mask
                   && micro.ir_field_picker == 4'h0
                   && micro.test_mode_select == 2'h0;

    property p_gpr0;
        !lit && micro.gpr_store_flag && micro.a_register_select == 4'h0
        |=> gpr0_word == $past(alu_result);
    endproperty
    a_gpr0: assert property (p_gpr0) else $error("gpr0 not written");
    property p_lit;
        lit |=> $stable(gpr0_word);
    endproperty
    a_lit: assert property (p_lit) else $error("gpr0 written");
    property p_pc;
        micro.special_dest_select == DEST_PC
        |=> program_counter == $past(alu_result);
    endproperty
    a_pc: assert property (p_pc) else $error("pc not loaded");
    property p_inc;
        micro.shcnt_inc && micro.special_dest_select != DEST_SHCNT
        |=> shift_counter == $past(shift_counter) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("counter no step");
    property p_ovf;
        shift_counter_ovf == (&shift_counter);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow wrong");
    property p_shl;
        !lit && micro.opreg_shift_on && !micro.shift_direction
        && micro.fill_bit_select == FILL_LAST
        && micro.special_dest_select[1:0] != 2'h3
        |=> operand_reg == {$past(operand_reg[14:0]), 1'b0};
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");
    property p_data;
        mem_xfer.data_load |-> $past(mem_cycle_started)
        && $past(micro.memory_cycle_code) != 2'h0;
    endproperty
    a_data: assert property (p_data) else $error("data load no cycle");
    property p_mir;
        micro.memory_cycle_code == 2'h0 && micro.memory_op_code == OP_MIR_LD
        |=> mem_xfer.mir_load;
    endproperty
    a_mir: assert property (p_mir) else $error("input reg no load");
    property p_csa;
        norm |=> control_store_addr
        == $past({micro.high_address_bits, micro.low_address_bits});
    endproperty
    a_csa: assert property (p_csa) else $error("or-in not blocked");
    c_data: cover property (mem_xfer.data_load);
    c_ovf: cover property (shift_counter_ovf);
    c_ior: cover property (mem_xfer.ior_load);
endmodule : mds_asserts

bind microcode_datapath_sequencer mds_asserts mds_asserts_i (
    .clk(clk), .reset(reset), .micro(micro), .alu_result(alu_result),
    .mem_cycle_started(mem_cycle_started), .gpr0_word(gpr0_word),
    .program_counter(program_counter), .operand_reg(operand_reg),
    .shift_counter(shift_counter), .shift_counter_ovf(shift_counter_ovf),
    .mem_xfer(mem_xfer), .control_store_addr(control_store_addr));

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import ucode_pkg::*;
    // ----------------------------------------
    // Stimulus, design outputs, model state
    // ----------------------------------------
    logic clk = 1'b0, reset = 1'b1, ia = 1'b0;
    micro_type micro = '0;
    logic [15:0] alu = 16'h0000, seed = 16'h000C;
    logic started, io_act, io_kld, ovf_q, sflag;
    logic [3:0] io_key, key = 4'h0, iok = 4'h0, ky;
    logic [15:0] a_word, g0, pc_q, op_q, maddr, g [16], ga;
    logic [15:0] pc = '0, op = '0, ar = '0, ma, wd;
    logic [7:0] sc_q, sc = '0;
    logic [8:0] csa, ca = '0;
    logic sf = 1'b0, dl, al, ml, il, kchk, mchk, io, b;
    logic [63:0] t;
    mem_xfer_type xfer;
    int error_cnt = 0;
    int cmp_count = 0;

    always #25 clk = ~clk;

    microcode_datapath_sequencer microcode_datapath_sequencer_i (
        .clk(clk), .reset(reset), .micro(micro), .alu_result(alu),
        .interrupts_allowed(ia), .mem_cycle_started(started),
        .io_mem_active(io_act), .io_key_load(io_kld), .io_key_in(io_key),
        .a_reg_word(a_word), .gpr0_word(g0), .program_counter(pc_q),
        .operand_reg(op_q), .shift_counter(sc_q), .shift_counter_ovf(ovf_q),
        .shift_out_flag(sflag), .mem_address(maddr), .mem_xfer(xfer),
        .control_store_addr(csa));
    mem_io_model mem_io_model_i (.clk(clk), .reset(reset),
        .mem_cycle_started(started), .io_mem_active(io_act),
        .io_key_load(io_kld), .io_key_in(io_key));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string n, input logic [63:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // One microinstruction: drive at falling edge, model, then compare
    task automatic step(input micro_type m, input logic [15:0] a, input logic i);
        micro = m;
        alu = a;
        ia = i;
        @(posedge clk);
        io = m.memory_cycle_code == 2'h0 && m.memory_op_code[3:1] == 3'h7;
        ga = g[m.a_register_select];
        dl = m.memory_cycle_code != 0 && m.memory_op_code[1] && started;
        al = m.memory_cycle_code != 0 && m.memory_op_code[3:2] == 2'h1 && started;
        ml = m.memory_cycle_code == 2'h0 && m.memory_op_code == OP_MIR_LD;
        il = io;
        mchk = m.special_dest_select != DEST_PC;
        ma = al ? a : pc + m.pc_inc;
        wd = a;
        ky = io_act ? iok : key;
        kchk = !io_kld && m.special_dest_select != DEST_KEY;
        b = m.shift_direction
          ? (m.fill_bit_select == 0 ? op[0] : m.fill_bit_select == 1 ? ga[0]
             : m.fill_bit_select == 2 ? op[15] : sf)
          : (m.fill_bit_select == 0 ? op[15] : m.fill_bit_select == 1 ? ga[15]
             : m.fill_bit_select == 2 ? ~a[15] : 1'b0);
        if (m.special_dest_select[1:0] == 2'h3) op = a;
        else if (!m.b_bus_source_select[1] && m.opreg_shift_on)
            op = m.shift_direction ? {b, op[15:1]} : {op[14:0], b};
        if (!m.b_bus_source_select[1] && m.gpr_shift_flag_sample) sf = ga[15];
        pc = m.special_dest_select == DEST_PC ? a : pc + m.pc_inc;
        sc = m.special_dest_select == DEST_SHCNT ? a[7:0] : sc + m.shcnt_inc;
        if (m.special_dest_select == DEST_KEY) key = a[3:0];
        if (io_kld) iok = io_key;
        if (m.gpr_store_flag && !m.b_bus_source_select[1])
            g[m.a_register_select] = a;
        ar = g[m.a_register_select];
        ca = {m.high_address_bits, m.low_address_bits};
        if (!(m.extract_control inside {2'h1, 2'h2}) && !i && !io
            && !(m.memory_cycle_code == 2'h2 && m.condition_select[2]))
            ca[4:1] = ca[4:1] | m.low_address_or_mask;
        @(negedge clk);
        check("gpr0", g0, g[0]);
        check("areg", a_word, ar);
        check("pc", pc_q, pc);
        check("opreg", op_q, op);
        check("shcnt", sc_q, sc);
        check("ovf", ovf_q, sc == 8'hFF);
        check("sflag", sflag, sf);
        check("loads", {xfer.data_load, xfer.addr_load, xfer.mir_load,
              xfer.ior_load}, {dl, al, ml, il});
        if (dl | al | ml | il) check("word", xfer.word, wd);
        if (mchk) check("maddr", maddr, ma);
        if (kchk) check("key", xfer.key, ky);
        check("csa", csa, ca);
    endtask : step

    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Hang guard
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        micro_type m;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        check("reset", {pc_q, op_q, sc_q, csa}, 64'h0);
        // Fill every general register
        for (int k = 0; k < 16; k++) begin
            m = '0;
            m.gpr_store_flag = 1'b1;
            m.a_register_select = 4'(k);
            seed = lfsr(seed);
            step(m, seed, 1'b0);
        end
        $display("register fill test done");
        // Counter through minus one
        m = '0;
        m.special_dest_select = DEST_SHCNT;
        step(m, 16'h00FE, 1'b0);
        m = '0;
        m.shcnt_inc = 1'b1;
        repeat (3) step(m, 16'h0000, 1'b0);
        $display("shift counter test done");
        repeat (800) begin
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                t = {t[47:0], seed};
            end
            m = t[$bits(micro_type)-1:0];
            m.test_mode_select = 2'h0;
            m.ir_field_picker = 4'h0;
            m.bit4_mask = 1'b0;
            if (m.special_dest_select == DEST_PC) m.pc_inc = 1'b0;
            if (m.special_dest_select == DEST_SHCNT) m.shcnt_inc = 1'b0;
            seed = lfsr(seed);
            // ALU input never taken from the counter
            step(m, seed, t[63] & t[62]);
        end
        $display("random microcode test done");
        final_report();
    end
endmodule : testbench
